//--- rtl/gpb_defines.vh
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define GPB_ADDR_W        4
`define GPB_OFF_DATA      4'h0
`define GPB_OFF_DIR       4'h1
`define GPB_OFF_LATCH     4'h2
`define GPB_OFF_ODRAIN    4'h3
`define GPB_OFF_SLEW      4'h4
`define GPB_OFF_THRESH    4'h5
`define GPB_OFF_ANALOG    4'h6
`define GPB_OFF_ROUTE     4'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPB_RST_DIR       8'hff
`define GPB_RST_LATCH     8'h00
`define GPB_RST_ODRAIN    8'h00
`define GPB_RST_SLEW      8'h00
`define GPB_RST_THRESH    8'h00
`define GPB_RST_ANALOG    8'hff
`define GPB_RST_ROUTE     8'h00

`endif

//--- rtl/gpb_pin_cell.v
`default_nettype none

// ----------------------------------------
// per-pin output and input conditioning
// ----------------------------------------
module gpb_pin_cell
(
  input  wire sys_clk_i,
  input  wire sys_rst_i,
  input  wire dir_i,
  input  wire latch_i,
  input  wire odrain_i,
  input  wire slew_i,
  input  wire analog_i,
  input  wire route_i,
  input  wire periph_out_i,
  input  wire periph_oe_i,
  input  wire pin_st_i,
  input  wire pin_ttl_i,
  input  wire thresh_i,
  output reg  pin_o,
  output reg  pin_oe_o,
  output reg  slew_o,
  output reg  analog_o,
  output reg  dig_in_o
);

  reg  src_val;
  reg  src_drive;

  always @*
  begin
    src_val   = route_i ? periph_out_i : latch_i; // RULE15
    src_drive = route_i ? (periph_oe_i & ~dir_i) : ~dir_i; // RULE2 RULE3 RULE6 RULE9
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
      slew_o   <= 1'b0;
      analog_o <= 1'b1;
      dig_in_o <= 1'b0;
    end
    else
    begin
      pin_o    <= odrain_i ? 1'b0 : src_val; // RULE11
      pin_oe_o <= src_drive & ~(odrain_i & src_val); // RULE11
      slew_o   <= slew_i; // RULE12
      analog_o <= analog_i; // RULE16
      dig_in_o <= analog_i ? 1'b0 : (thresh_i ? pin_ttl_i : pin_st_i); // RULE8 RULE13
    end
  end

endmodule

`default_nettype wire

//--- rtl/gpb_port.v
// Behaviour
// RULE1: eight pins, each with own direction, latch and configuration bits.
// RULE2: direction one puts the pin driver into high impedance.
// RULE3: direction zero enables the driver with the latch value.
// RULE4: data read returns pin levels; data write updates the latch.
// RULE5: writes are read-modify-write on pin levels, result stored in latch; data writes use an all-ones mask and store the write data.
// RULE6: direction controls drivers even for analog pins.
// RULE7: software keeps direction set on analog pins.
// RULE8: analog select forces digital reads to zero, enables analog functions.
// RULE9: analog select does not block digital output.
// RULE10: analog select resets to analog; software clears before digital input.
// RULE11: open-drain select makes output sink only, else push-pull.
// RULE12: slew select asserts pad slew limiting, else full rate.
// RULE13: threshold select picks Schmitt or TTL for reads and change detect.
// RULE14: software changes threshold only with peripherals disabled.
// RULE15: after reset pins output latch; routing brings peripheral outputs.
// RULE16: analog mode connects analog inputs; routed outputs may still drive.
// RULE17: reset sets all direction bits, pins start as inputs.
// RULE18: latch register reads the stored latch, not pin levels.
`include "gpb_defines.vh"
`default_nettype none

module gpb_port
#(
  parameter WIDTH = 8
)
(
  input  wire                   sys_clk_i,
  input  wire                   sys_rst_i,
  input  wire [`GPB_ADDR_W-1:0] addr_i,
  input  wire [WIDTH-1:0]       wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [WIDTH-1:0]       rdata_o,
  input  wire [WIDTH-1:0]       pin_st_i,
  input  wire [WIDTH-1:0]       pin_ttl_i,
  input  wire [WIDTH-1:0]       periph_out_i,
  input  wire [WIDTH-1:0]       periph_oe_i,
  output wire [WIDTH-1:0]       pin_o,
  output wire [WIDTH-1:0]       pin_oe_o,
  output wire [WIDTH-1:0]       slew_limit_o,
  output wire [WIDTH-1:0]       analog_en_o,
  output wire [WIDTH-1:0]       pin_level_o
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg  [WIDTH-1:0] pin_direction_mask_reg;
  reg  [WIDTH-1:0] pin_output_latch_reg;
  reg  [WIDTH-1:0] open_drain_select_reg;
  reg  [WIDTH-1:0] slew_limit_select_reg;
  reg  [WIDTH-1:0] input_threshold_select_reg;
  reg  [WIDTH-1:0] analog_input_select_reg;
  reg  [WIDTH-1:0] peripheral_pin_routing_reg;
  reg  [WIDTH-1:0] pin_direction_mask_next;
  reg  [WIDTH-1:0] pin_output_latch_next;
  reg  [WIDTH-1:0] open_drain_select_next;
  reg  [WIDTH-1:0] slew_limit_select_next;
  reg  [WIDTH-1:0] input_threshold_select_next;
  reg  [WIDTH-1:0] analog_input_select_next;
  reg  [WIDTH-1:0] peripheral_pin_routing_next;
  reg  [WIDTH-1:0] rdata_next;
  wire [WIDTH-1:0] port_pin_data;
  wire             wr_data_hit;
  wire             wr_dir_hit;
  wire             wr_latch_hit;
  wire             wr_odrain_hit;
  wire             wr_slew_hit;
  wire             wr_thresh_hit;
  wire             wr_analog_hit;
  wire             wr_route_hit;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // one register index against one offset
  function addr_hit;
    input [`GPB_ADDR_W-1:0] addr;
    input [`GPB_ADDR_W-1:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // keep unmasked pin levels, take masked write bits
  function [WIDTH-1:0] rmw_merge;
    input [WIDTH-1:0] pins;
    input [WIDTH-1:0] wdata;
    input [WIDTH-1:0] mask;
    begin
      rmw_merge = (pins & ~mask) | (wdata & mask);
    end
  endfunction

  // write value on a hit, else hold
  function [WIDTH-1:0] reg_update;
    input             hit;
    input [WIDTH-1:0] wdata;
    input [WIDTH-1:0] cur;
    begin
      if (hit)
        reg_update = wdata;
      else
        reg_update = cur;
    end
  endfunction

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  assign wr_data_hit   = wr_i & addr_hit(addr_i, `GPB_OFF_DATA);
  assign wr_dir_hit    = wr_i & addr_hit(addr_i, `GPB_OFF_DIR);
  assign wr_latch_hit  = wr_i & addr_hit(addr_i, `GPB_OFF_LATCH);
  assign wr_odrain_hit = wr_i & addr_hit(addr_i, `GPB_OFF_ODRAIN);
  assign wr_slew_hit   = wr_i & addr_hit(addr_i, `GPB_OFF_SLEW);
  assign wr_thresh_hit = wr_i & addr_hit(addr_i, `GPB_OFF_THRESH);
  assign wr_analog_hit = wr_i & addr_hit(addr_i, `GPB_OFF_ANALOG);
  assign wr_route_hit  = wr_i & addr_hit(addr_i, `GPB_OFF_ROUTE);

  // ----------------------------------------
  // pin direction
  // ----------------------------------------
  always @*
  begin
    pin_direction_mask_next = reg_update(wr_dir_hit,
                                         wdata_i,
                                         pin_direction_mask_reg); // RULE2 RULE3
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      pin_direction_mask_reg <= `GPB_RST_DIR; // RULE17
    else
      pin_direction_mask_reg <= pin_direction_mask_next;
  end

  // ----------------------------------------
  // output latch
  // ----------------------------------------
  // data write merges with an all-ones mask so no pin levels are kept, latch write stores directly
  always @*
  begin
    pin_output_latch_next = pin_output_latch_reg;
    if (wr_data_hit)
      pin_output_latch_next = rmw_merge(port_pin_data, wdata_i, {WIDTH{1'b1}}); // RULE5
    else if (wr_latch_hit)
      pin_output_latch_next = wdata_i;
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      pin_output_latch_reg <= `GPB_RST_LATCH; // RULE15
    else
      pin_output_latch_reg <= pin_output_latch_next;
  end

  // ----------------------------------------
  // open-drain select
  // ----------------------------------------
  always @*
  begin
    open_drain_select_next = reg_update(wr_odrain_hit,
                                        wdata_i,
                                        open_drain_select_reg); // RULE11
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      open_drain_select_reg <= `GPB_RST_ODRAIN;
    else
      open_drain_select_reg <= open_drain_select_next;
  end

  // ----------------------------------------
  // slew limit select
  // ----------------------------------------
  always @*
  begin
    slew_limit_select_next = reg_update(wr_slew_hit,
                                        wdata_i,
                                        slew_limit_select_reg); // RULE12
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      slew_limit_select_reg <= `GPB_RST_SLEW;
    else
      slew_limit_select_reg <= slew_limit_select_next;
  end

  // ----------------------------------------
  // input threshold select
  // ----------------------------------------
  always @*
  begin
    input_threshold_select_next = reg_update(wr_thresh_hit,
                                             wdata_i,
                                             input_threshold_select_reg); // RULE13
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      input_threshold_select_reg <= `GPB_RST_THRESH;
    else
      input_threshold_select_reg <= input_threshold_select_next;
  end

  // ----------------------------------------
  // analog input select
  // ----------------------------------------
  always @*
  begin
    analog_input_select_next = reg_update(wr_analog_hit,
                                          wdata_i,
                                          analog_input_select_reg); // RULE8
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      analog_input_select_reg <= `GPB_RST_ANALOG; // RULE10
    else
      analog_input_select_reg <= analog_input_select_next;
  end

  // ----------------------------------------
  // peripheral routing
  // ----------------------------------------
  always @*
  begin
    peripheral_pin_routing_next = reg_update(wr_route_hit,
                                             wdata_i,
                                             peripheral_pin_routing_reg); // RULE15
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      peripheral_pin_routing_reg <= `GPB_RST_ROUTE; // RULE15
    else
      peripheral_pin_routing_reg <= peripheral_pin_routing_next;
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always @*
  begin
    case (addr_i)
      `GPB_OFF_DATA:   rdata_next = port_pin_data; // RULE4
      `GPB_OFF_DIR:    rdata_next = pin_direction_mask_reg;
      `GPB_OFF_LATCH:  rdata_next = pin_output_latch_reg; // RULE18
      `GPB_OFF_ODRAIN: rdata_next = open_drain_select_reg;
      `GPB_OFF_SLEW:   rdata_next = slew_limit_select_reg;
      `GPB_OFF_THRESH: rdata_next = input_threshold_select_reg;
      `GPB_OFF_ANALOG: rdata_next = analog_input_select_reg;
      `GPB_OFF_ROUTE:  rdata_next = peripheral_pin_routing_reg;
      default:         rdata_next = {WIDTH{1'b0}};
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      rdata_o <= {WIDTH{1'b0}};
    else if (rd_i)
      rdata_o <= rdata_next;
    else
      rdata_o <= {WIDTH{1'b0}};
  end

  // ----------------------------------------
  // pin cells
  // ----------------------------------------
  assign pin_level_o = port_pin_data;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_pin
      // RULE1 RULE2 RULE3 RULE6 RULE9 RULE11 RULE12 RULE13 RULE8 RULE16
      gpb_pin_cell u_cell
      (
        .sys_clk_i    (sys_clk_i),
        .sys_rst_i    (sys_rst_i),
        .dir_i        (pin_direction_mask_reg[i]),
        .latch_i      (pin_output_latch_reg[i]),
        .odrain_i     (open_drain_select_reg[i]),
        .slew_i       (slew_limit_select_reg[i]),
        .analog_i     (analog_input_select_reg[i]),
        .route_i      (peripheral_pin_routing_reg[i]),
        .periph_out_i (periph_out_i[i]),
        .periph_oe_i  (periph_oe_i[i]),
        .pin_st_i     (pin_st_i[i]),
        .pin_ttl_i    (pin_ttl_i[i]),
        .thresh_i     (input_threshold_select_reg[i]),
        .pin_o        (pin_o[i]),
        .pin_oe_o     (pin_oe_o[i]),
        .slew_o       (slew_limit_o[i]),
        .analog_o     (analog_en_o[i]),
        .dig_in_o     (port_pin_data[i])
      );
    end
  endgenerate

endmodule

`default_nettype wire

//--- test/gpb_pad_model.sv
`default_nettype none
module gpb_pad_model
(
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ttl_flip,
  output logic      [7:0] pin_st_i,
  output logic      [7:0] pin_ttl_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pads follow the outside drive
  assign pin_st_i  = (pin_oe_o & pin_o) | (~pin_oe_o & ext_val);
  assign pin_ttl_i = pin_st_i ^ ttl_flip;
endmodule
`default_nettype wire

//--- test/gpb_port_properties.sv
`default_nettype none
module gpb_port_properties
(
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] slew_limit_o,
  input wire logic [7:0] analog_en_o,
  input wire logic [7:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire w_dir = wr_i && addr_i == 4'h1;
  wire w_slw = wr_i && addr_i == 4'h4;
  wire w_ana = wr_i && addr_i == 4'h6;
  a_reset_state: assert property ($past(sys_rst_i) |-> !pin_oe_o && &analog_en_o)
    else $error("pins not idle after reset");
  a_idle_rdata: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
  a_unmapped_rd: assert property (rd_i && addr_i[3] |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_dir_input: assert property (w_dir && &wdata_i ##1 !w_dir |=> !pin_oe_o)
    else $error("input pin driven");
  a_slew_follow: assert property (w_slw ##1 !w_slw |=> slew_limit_o == $past(wdata_i, 2))
    else $error("slew control wrong");
  a_analog_follow: assert property (w_ana ##1 !w_ana |=> analog_en_o == $past(wdata_i, 2))
    else $error("analog connect wrong");
  a_analog_zero: assert property ($stable(analog_en_o)[*2] |-> !(pin_level_o & analog_en_o))
    else $error("analog pin reads one");
  a_latch_rmw: assert property (wr_i && !addr_i ##1 rd_i && addr_i == 4'h2
    |=> rdata_o == $past(wdata_i, 2)) else $error("latch not written");
  a_data_read: assert property (rd_i && !addr_i ##1 $stable(pin_level_o)
    |-> rdata_o == pin_level_o) else $error("data read not pin level");
  c_odrain: cover property (|pin_oe_o && !(&pin_oe_o));
  c_slew: cover property (|slew_limit_o);
  c_read: cover property (rd_i ##1 |rdata_o);
endmodule
bind gpb_port gpb_port_properties i_props (.*);
`default_nettype wire

//--- test/gpb_port_tb.sv
`default_nettype none
module gpb_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, periph_out_i = 8'h00, periph_oe_i = 8'h00;
  logic [7:0] ext_val = 8'h30, ttl_flip = 8'h00;
  wire  [7:0] rdata_o, pin_st_i, pin_ttl_i, pin_o, pin_oe_o, slew_limit_o;
  wire  [7:0] analog_en_o, pin_level_o;
  int         error_cnt = 0, checks = 0;
  gpb_port      i_dut (.*);
  gpb_pad_model i_pad (.*);
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got === exp) return;
    error_cnt++;
    $display("[ERR] %0t got %h want %h", $time, got, exp);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    rd_i <= 1'b0;
    @(posedge sys_clk_i);
    chk(rdata_o, e);
  endtask
  task automatic sett;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic t_reset;
    chk(pin_oe_o, 8'h00);
    rd(4'h1, 8'hff);
    rd(4'h6, 8'hff);
    for (int a = 2; a < 6; a++) rd(a[3:0], 8'h00);
    rd(4'h7, 8'h00);
  endtask
  task automatic t_drive;
    bus(1'b1, 4'h6, 8'h00);
    bus(1'b1, 4'h0, 8'ha5);
    rd(4'h2, 8'ha5);
    bus(1'b1, 4'h1, 8'hf0);
    sett;
    chk(pin_oe_o, 8'h0f);
    chk(pin_o & 8'h0f, 8'h05);
    rd(4'h0, 8'h35);
    bus(1'b1, 4'h6, 8'h01);
    sett;
    chk(pin_oe_o & pin_o, 8'h05);
    chk(analog_en_o, 8'h01);
    rd(4'h0, 8'h34);
    bus(1'b1, 4'h6, 8'h00);
  endtask
  task automatic t_odrain;
    bus(1'b1, 4'h3, 8'h0f);
    sett;
    chk(pin_oe_o, 8'h0a);
    rd(4'h0, 8'h30);
    bus(1'b1, 4'h3, 8'h00);
  endtask
  task automatic t_thresh;
    bus(1'b1, 4'h4, 8'hc3);
    ttl_flip <= 8'hf0;
    bus(1'b1, 4'h5, 8'hff);
    sett;
    chk(slew_limit_o, 8'hc3);
    chk(pin_level_o, 8'hc5);
    rd(4'h0, 8'hc5);
    bus(1'b1, 4'h5, 8'h00);
  endtask
  task automatic t_route;
    periph_oe_i <= 8'hff;
    periph_out_i <= 8'h01;
    bus(1'b1, 4'h7, 8'h81);
    sett;
    chk(pin_oe_o, 8'h0f);
    chk(pin_o & 8'h0f, 8'h05);
    bus(1'b1, 4'h6, 8'h01);
    sett;
    chk(pin_oe_o & pin_o, 8'h05);
    rd(4'h0, 8'h34);
    bus(1'b1, 4'h6, 8'h00);
    rd(4'h9, 8'h00);
    bus(1'b1, 4'h1, 8'hff);
    sett;
    chk(pin_oe_o, 8'h00);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    sett;
    t_reset;
    t_drive;
    t_odrain;
    t_thresh;
    t_route;
    complete_run;
  end
  initial
  begin
    #5000;
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
